//--- hdl/fbm_pkg.sv
package fbm_pkg;

  // Timing.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MS_NS          = 1000000;
  localparam int unsigned MS_CYCLES_DFLT = MS_NS / CLK_PERIOD_NS;

  // Slave table and per-node timeout words.
  localparam int unsigned NODES     = 64;
  localparam logic [7:0]  TMO_WORDS = 8'h04;
  localparam logic [7:0]  STAT_OFS  = 8'h04;
  localparam logic [5:0]  LAST_NODE = 6'h3f;

  // Rate select codes and processing-time coefficients in microseconds per unit.
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_250K = 2'h1;
  localparam logic [1:0] RATE_125K = 2'h2;
  localparam logic [3:0] COEF_500K = 4'h2;
  localparam logic [3:0] COEF_250K = 4'h4;
  localparam logic [3:0] COEF_125K = 4'h8;

  // Processing time terms; the base is in rate units, the frame times in microseconds.
  localparam logic [12:0] BASE_UNITS  = 13'h005e;
  localparam logic [9:0]  TX_FRAME_US = 10'h1f4;
  localparam logic [9:0]  RX_FRAME_US = 10'h12c;
  localparam logic [9:0]  US_PER_MS   = 10'h3e8;

  // Fragmentation.
  localparam logic [8:0] SINGLE_FRAME_MAX = 9'h008;
  localparam logic [9:0] FRAG_ROUND       = 10'h006;
  localparam logic [9:0] FRAG_PAYLOAD     = 10'h007;

  // Transmission cycle steps in ms.
  localparam logic [11:0] CYC_1000 = 12'h3e8;
  localparam logic [11:0] CYC_500  = 12'h1f4;
  localparam logic [11:0] CYC_200  = 12'h0c8;
  localparam logic [11:0] CYC_100  = 12'h064;
  localparam logic [11:0] CYC_50   = 12'h032;
  localparam logic [11:0] CYC_20   = 12'h014;
  localparam logic [11:0] CYC_10   = 12'h00a;

  // Status word bit positions and reset value.
  localparam int unsigned SB_BUS_OFF    = 0;
  localparam int unsigned SB_TX_TMO     = 1;
  localparam int unsigned SB_ANY_TMO    = 2;
  localparam int unsigned SB_NODE_ERR   = 3;
  localparam int unsigned SB_FRAME_LOST = 4;
  localparam int unsigned SB_BUSY       = 5;
  localparam logic [15:0] STATUS_RST    = 16'h0000;

  typedef struct packed {
    logic       present;
    logic [8:0] out_bytes;
    logic [8:0] in_bytes;
  } fbm_entry_t;

  typedef struct packed {
    logic [5:0] node;
    logic [5:0] tx_frames;
    logic [5:0] rx_frames;
    logic [8:0] out_bytes;
    logic [8:0] in_bytes;
  } fbm_poll_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_ISSUE = 2'b11,
    ST_WAIT  = 2'b10
  } fbm_state_t;

endpackage : fbm_pkg

//--- hdl/fbm_slave_ram.sv
`timescale 1ns/1ps
module fbm_slave_ram
  import fbm_pkg::*;
(
  // Clock.
  input  wire logic       clk,
  // Write port.
  input  wire logic       we,
  input  wire logic [5:0] waddr,
  input  fbm_entry_t      wdata,
  // Read port, data one cycle after the address.
  input  wire logic [5:0] raddr,
  output fbm_entry_t      rdata
);

  fbm_entry_t mem [NODES];

  // No reset on the array; software loads the table before enabling the master role.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : fbm_slave_ram

//--- hdl/fbm_scan_sched.sv
`timescale 1ns/1ps
module fbm_scan_sched
  import fbm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DFLT
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration.
  input  wire logic        role_master,
  input  wire logic [1:0]  rate_sel,
  input  wire logic [11:0] refresh_ms,
  input  wire logic [2:0]  tmo_area,
  input  wire logic [7:0]  tmo_base,
  // Slave table load.
  input  wire logic        tbl_we,
  input  wire logic [5:0]  tbl_node,
  input  fbm_entry_t       tbl_entry,
  // Host word port.
  input  wire logic        host_rd,
  input  wire logic        host_wr,
  input  wire logic [2:0]  host_area,
  input  wire logic [7:0]  host_addr,
  input  wire logic [15:0] host_wdata,
  output logic [15:0]      host_rdata,
  output logic             host_rvalid,
  // Network events from the CAN side.
  input  wire logic        rx_ok,
  input  wire logic        rx_timeout,
  input  wire logic [5:0]  rx_node,
  input  wire logic        node_err,
  input  wire logic        bus_off,
  input  wire logic        can_tx_tmo,
  input  wire logic        poll_done,
  // Scheduler outputs.
  output logic             poll_req,
  output fbm_poll_t        poll,
  output logic             cycle_tick,
  output logic [15:0]      status_word
);

  function automatic logic [5:0] frames(input logic [8:0] n);
    logic [9:0] t;
    t = {1'b0, n} + FRAG_ROUND;
    if (n <= SINGLE_FRAME_MAX) begin
      return 6'h01;
    end
    return 6'(t / FRAG_PAYLOAD);
  endfunction : frames

  function automatic logic [11:0] quant(input logic [11:0] r);
    if (r >= CYC_1000) return CYC_1000;
    if (r >= CYC_500) return CYC_500;
    if (r >= CYC_200) return CYC_200;
    if (r >= CYC_100) return CYC_100;
    if (r >= CYC_50) return CYC_50;
    if (r >= CYC_20) return CYC_20;
    return CYC_10;
  endfunction : quant

  // Timer group.
  logic [16:0] ms_cnt_q, ms_cnt_d;
  logic [11:0] cyc_cnt_q, cyc_cnt_d;
  logic        due_q, due_d;
  logic [11:0] cyc_ms;

  // Sweep group.
  fbm_state_t  st_q, st_d;
  logic [5:0]  idx_q, idx_d;
  logic [23:0] acc_q, acc_d;
  logic        pend_q, pend_d;
  logic        overload_q, overload_d;
  logic        lost_evt_q, lost_evt_d;
  logic        poll_req_d, cycle_tick_d;
  fbm_poll_t   poll_d;
  fbm_entry_t  ent;
  logic [3:0]  coef;
  logic [23:0] slave_us;
  logic [23:0] refresh_us;
  logic [5:0]  fs, fr;

  // Flag and host group.
  logic [63:0] tmo_q, tmo_d;
  logic [15:0] status_d, host_rdata_d;
  logic        node_err_q, node_err_d, lost_q, lost_d;
  logic [7:0]  off;
  logic        hit_tmo, hit_stat;

  fbm_slave_ram u_ram (
    .clk   (clk),
    .we    (tbl_we),
    .waddr (tbl_node),
    .wdata (tbl_entry),
    .raddr (idx_q),
    .rdata (ent)
  );

  assign cyc_ms = quant(refresh_ms);

  always_comb begin
    ms_cnt_d  = ms_cnt_q + 17'h00001;
    cyc_cnt_d = cyc_cnt_q;
    due_d     = 1'b0;
    if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
      ms_cnt_d  = 17'h00000;
      cyc_cnt_d = cyc_cnt_q + 12'h001;
      if (cyc_cnt_q + 12'h001 >= cyc_ms) begin
        cyc_cnt_d = 12'h000;
        due_d     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ms_cnt_q  <= 17'h00000;
      cyc_cnt_q <= 12'h000;
      due_q     <= 1'b0;
    end else begin
      ms_cnt_q  <= ms_cnt_d;
      cyc_cnt_q <= cyc_cnt_d;
      due_q     <= due_d;
    end
  end

  always_comb begin
    unique case (rate_sel)
      RATE_500K: coef = COEF_500K;
      RATE_250K: coef = COEF_250K;
      default:   coef = COEF_125K;
    endcase
  end

  assign fs = frames(ent.out_bytes);
  assign fr = frames(ent.in_bytes);
  assign slave_us = (24'(BASE_UNITS) + 24'({ent.out_bytes, 3'h0}) + 24'({ent.in_bytes, 3'h0})) * 24'(coef)
                  + 24'(fs) * 24'(TX_FRAME_US) + 24'(fr) * 24'(RX_FRAME_US);
  assign refresh_us = 24'(refresh_ms) * 24'(US_PER_MS);

  always_comb begin
    st_d         = st_q;
    idx_d        = idx_q;
    acc_d        = acc_q;
    pend_d       = pend_q | due_q;
    overload_d   = overload_q;
    lost_evt_d   = 1'b0;
    poll_req_d   = 1'b0;
    cycle_tick_d = 1'b0;
    poll_d       = poll;
    if (due_q && (pend_q || st_q != ST_IDLE)) begin
      lost_evt_d = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        if (pend_q && role_master) begin
          pend_d       = due_q;
          cycle_tick_d = 1'b1;
          idx_d        = 6'h00;
          acc_d        = 24'h000000;
          st_d         = ST_READ;
        end
      end
      ST_READ: st_d = ST_ISSUE;
      ST_ISSUE, ST_WAIT: begin
        if (st_q == ST_ISSUE && ent.present) begin
          poll_req_d = 1'b1;
          poll_d     = '{node: idx_q, tx_frames: fs, rx_frames: fr,
                         out_bytes: ent.out_bytes, in_bytes: ent.in_bytes};
          acc_d      = acc_q + slave_us;
          st_d       = ST_WAIT;
        end else if (st_q == ST_ISSUE || poll_done) begin
          if (idx_q == LAST_NODE) begin
            overload_d = acc_q > refresh_us;
            st_d       = ST_IDLE;
          end else begin
            idx_d = idx_q + 6'h01;
            st_d  = ST_READ;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q       <= ST_IDLE;
      idx_q      <= 6'h00;
      acc_q      <= 24'h000000;
      pend_q     <= 1'b0;
      overload_q <= 1'b0;
      lost_evt_q <= 1'b0;
      poll_req   <= 1'b0;
      cycle_tick <= 1'b0;
      poll       <= '0;
    end else begin
      st_q       <= st_d;
      idx_q      <= idx_d;
      acc_q      <= acc_d;
      pend_q     <= pend_d;
      overload_q <= overload_d;
      lost_evt_q <= lost_evt_d;
      poll_req   <= poll_req_d;
      cycle_tick <= cycle_tick_d;
      poll       <= poll_d;
    end
  end

  assign off      = host_addr - tmo_base;
  assign hit_tmo  = (host_area == tmo_area) && (off < TMO_WORDS);
  assign hit_stat = (host_area == tmo_area) && (off == STAT_OFS);

  always_comb begin
    tmo_d = tmo_q;
    if (rx_ok) begin
      tmo_d[rx_node] = 1'b0;
    end
    if (rx_timeout) begin
      tmo_d[rx_node] = 1'b1;
    end
    if (!role_master) begin
      tmo_d = 64'h0;
    end
    // Sticky bits; a host write of one clears, a new event in the same cycle wins.
    node_err_d = node_err_q;
    lost_d     = lost_q;
    if (host_wr && hit_stat) begin
      node_err_d = node_err_q & ~host_wdata[SB_NODE_ERR];
      lost_d     = lost_q & ~host_wdata[SB_FRAME_LOST];
    end
    if (node_err || rx_timeout) begin
      node_err_d = 1'b1;
    end
    if (lost_evt_q) begin
      lost_d = 1'b1;
    end
    status_d                = STATUS_RST;
    status_d[SB_BUS_OFF]    = bus_off;
    status_d[SB_TX_TMO]     = can_tx_tmo | overload_q;
    status_d[SB_ANY_TMO]    = |tmo_q;
    status_d[SB_NODE_ERR]   = node_err_q;
    status_d[SB_FRAME_LOST] = lost_q;
    status_d[SB_BUSY]       = st_q != ST_IDLE;
    host_rdata_d = 16'h0000;
    if (hit_tmo) begin
      host_rdata_d = tmo_q[{off[1:0], 4'h0} +: 16];
    end else if (hit_stat) begin
      host_rdata_d = status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tmo_q       <= 64'h0;
      node_err_q  <= 1'b0;
      lost_q      <= 1'b0;
      status_word <= STATUS_RST;
      host_rdata  <= 16'h0000;
      host_rvalid <= 1'b0;
    end else begin
      tmo_q       <= tmo_d;
      node_err_q  <= node_err_d;
      lost_q      <= lost_d;
      status_word <= status_d;
      host_rdata  <= host_rd ? host_rdata_d : host_rdata;
      host_rvalid <= host_rd;
    end
  end

  AST_WORD_READ: assert property (@(posedge clk) disable iff (rst) host_rd |=> host_rvalid)
    else $error("read not answered in one cycle");
  AST_TMO_SET: assert property (@(posedge clk) disable iff (rst)
    role_master && rx_timeout |=> tmo_q[$past(rx_node)])
    else $error("timeout bit not set");
  AST_TMO_CLR: assert property (@(posedge clk) disable iff (rst)
    role_master && rx_ok && !rx_timeout |=> !tmo_q[$past(rx_node)])
    else $error("timeout bit not cleared");
  AST_SLAVE_ROLE: assert property (@(posedge clk) disable iff (rst) !role_master |=> tmo_q == 64'h0)
    else $error("timeout bits present in slave role");
  AST_BUS_OFF: assert property (@(posedge clk) disable iff (rst) $fell(bus_off) |=> !status_word[SB_BUS_OFF])
    else $error("bus-off bit did not clear");
  AST_NODE_ERR: assert property (@(posedge clk) disable iff (rst) node_err |=> ##1 status_word[SB_NODE_ERR])
    else $error("node error not reported");
  AST_QUANT: assert property (@(posedge clk) disable iff (rst)
    refresh_ms >= CYC_20 && refresh_ms < CYC_50 |-> cyc_ms == CYC_20)
    else $error("cycle quantization wrong");
  AST_TX_FRAMES: assert property (@(posedge clk) disable iff (rst)
    poll_req |-> (poll.out_bytes <= SINGLE_FRAME_MAX) ? poll.tx_frames == 6'h01
      : (poll.tx_frames * 7 >= poll.out_bytes && (poll.tx_frames - 1) * 7 < poll.out_bytes))
    else $error("tx frame count wrong");
  AST_RX_FRAMES: assert property (@(posedge clk) disable iff (rst)
    poll_req |-> (poll.in_bytes <= SINGLE_FRAME_MAX) ? poll.rx_frames == 6'h01
      : (poll.rx_frames * 7 >= poll.in_bytes && (poll.rx_frames - 1) * 7 < poll.in_bytes))
    else $error("rx frame count wrong");
  AST_OVERLOAD: assert property (@(posedge clk) disable iff (rst) $rose(overload_q) |=> status_word[SB_TX_TMO])
    else $error("overload not reported");
  AST_TICK: assert property (@(posedge clk) disable iff (rst) cycle_tick |=> !cycle_tick && !poll_req)
    else $error("cycle start malformed");

  COV_POLL: cover property (@(posedge clk) disable iff (rst) poll_req && poll.tx_frames > 6'h01);
  COV_OVERLOAD: cover property (@(posedge clk) disable iff (rst) $rose(overload_q));
  COV_TMO: cover property (@(posedge clk) disable iff (rst) rx_timeout ##[1:300] rx_ok);
  COV_HOST: cover property (@(posedge clk) disable iff (rst) host_rd && hit_tmo && role_master);

endmodule : fbm_scan_sched

//--- verif/fbm_slave_model.sv
`timescale 1ns/1ps
module fbm_slave_model
  import fbm_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Poll from the scheduler.
  input  wire logic       poll_req,
  input  fbm_poll_t       poll,
  // Behaviour selects.
  input  wire logic       slow,
  input  wire logic [5:0] drop_node,
  // Answers.
  output logic            poll_done,
  output logic            rx_ok,
  output logic            rx_timeout,
  output logic [5:0]      rx_node
);
  logic [2:0] wait_q;
  logic [5:0] node_q;

  always_ff @(posedge clk) begin
    poll_done  <= 1'b0;
    rx_ok      <= 1'b0;
    rx_timeout <= 1'b0;
    // Outside an answer the node lines mean nothing, so they keep changing.
    rx_node    <= ~rx_node;
    if (rst) begin
      wait_q  <= 3'h0;
      rx_node <= 6'h00;
    end else if (poll_req) begin
      node_q <= poll.node;
      wait_q <= slow ? 3'h6 : 3'h2;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
      if (wait_q == 3'h1) begin
        poll_done  <= 1'b1;
        rx_node    <= node_q;
        rx_timeout <= (node_q == drop_node);
        rx_ok      <= (node_q != drop_node);
      end
    end
  end
endmodule : fbm_slave_model

//--- verif/tb_fieldbus_master_scan_scheduler.sv
`timescale 1ns/1ps
module tb_fieldbus_master_scan_scheduler
  import fbm_pkg::*;
;
  logic clk, rst, role_master, tbl_we, host_rd, host_wr, host_rvalid;
  logic node_err, bus_off, can_tx_tmo, poll_done, poll_req, cycle_tick;
  logic rx_ok, rx_timeout, slow;
  logic [1:0]  rate_sel;
  logic [11:0] refresh_ms;
  logic [2:0]  tmo_area, host_area;
  logic [7:0]  tmo_base, host_addr;
  logic [5:0]  tbl_node, rx_node, drop_node;
  logic [15:0] host_wdata, host_rdata, status_word, rd;
  fbm_entry_t  tbl_entry;
  fbm_poll_t   poll;
  int          errors, compares, n;

  fbm_scan_sched #(.MS_CYCLES(10)) uut (.clk(clk), .rst(rst), .role_master(role_master),
    .rate_sel(rate_sel), .refresh_ms(refresh_ms), .tmo_area(tmo_area), .tmo_base(tmo_base),
    .tbl_we(tbl_we), .tbl_node(tbl_node), .tbl_entry(tbl_entry), .host_rd(host_rd),
    .host_wr(host_wr), .host_area(host_area), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .rx_ok(rx_ok), .rx_timeout(rx_timeout),
    .rx_node(rx_node), .node_err(node_err), .bus_off(bus_off), .can_tx_tmo(can_tx_tmo),
    .poll_done(poll_done), .poll_req(poll_req), .poll(poll), .cycle_tick(cycle_tick),
    .status_word(status_word));

  fbm_slave_model peer (.clk(clk), .rst(rst), .poll_req(poll_req), .poll(poll), .slow(slow),
    .drop_node(drop_node), .poll_done(poll_done), .rx_ok(rx_ok), .rx_timeout(rx_timeout),
    .rx_node(rx_node));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic close_out;
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic host_rw(input logic wr, input logic [2:0] area, input logic [7:0] ofs,
                         input logic [15:0] wdata);
    @(posedge clk);
    host_rd    <= ~wr;
    host_wr    <= wr;
    host_area  <= area;
    host_addr  <= tmo_base + ofs;
    host_wdata <= wdata;
    @(posedge clk);
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    @(negedge clk);
    if (!wr) chk("rvalid", host_rvalid, 1'b1);
    rd = host_rdata;
  endtask : host_rw

  task automatic wait_tick;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cycle_tick !== 1'b1 && n < 20000);
  endtask : wait_tick

  task automatic test_scan;
    logic [5:0] exp_q[9] = '{6'd1, 6'd3, 6'd1, 6'd2, 6'd2, 6'd1, 6'd40, 6'd37, 6'd37};
    wait_tick();
    for (int i = 0; i < 9; i += 3) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (poll_req !== 1'b1 && n < 200);
      chk("poll node", poll.node, exp_q[i]);
      chk("tx frames", poll.tx_frames, exp_q[i+1]);
      chk("rx frames", poll.rx_frames, exp_q[i+2]);
      if (i == 0) chk("sweep busy", status_word[SB_BUSY], 1'b1);
    end
    $display("test_scan done");
  endtask : test_scan

  task automatic test_cycle(input logic [11:0] ms, input int exp);
    @(posedge clk);
    refresh_ms <= ms;
    wait_tick();
    wait_tick();
    wait_tick();
    chk("cycle length", n, exp);
    $display("test_cycle %0d done", ms);
  endtask : test_cycle

  task automatic test_timeout;
    slow      = 1'b1;
    drop_node = 6'd40;
    repeat (2) wait_tick();
    host_rw(1'b0, 3'h5, 8'h02, 16'h0000);
    chk("tmo word 2", rd, 16'h0100);
    chk("status any tmo, node err", status_word[3:2], 2'b11);
    host_rw(1'b0, 3'h4, 8'h02, 16'h0000);
    chk("other area", rd, 16'h0000);
    drop_node = 6'd63;
    repeat (2) wait_tick();
    host_rw(1'b0, 3'h5, 8'h02, 16'h0000);
    chk("tmo cleared", rd, 16'h0000);
    host_rw(1'b1, 3'h5, 8'h04, 16'h0018);
    host_rw(1'b0, 3'h5, 8'h04, 16'h0000);
    chk("sticky cleared", rd[4:2], 3'b000);
    @(posedge clk);
    node_err <= 1'b1;
    @(posedge clk);
    node_err <= 1'b0;
    repeat (3) @(negedge clk);
    chk("node error bit", status_word[3], 1'b1);
    slow = 1'b0;
    $display("test_timeout done");
  endtask : test_timeout

  task automatic test_load;
    logic exp_q[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      rate_sel <= r[1:0];
      repeat (2) wait_tick();
      chk("overload", status_word[SB_TX_TMO], exp_q[r]);
    end
    // Deliberate overload: a 10 ms cycle is shorter than both the summed time and the 64-node sweep.
    @(posedge clk);
    rate_sel   <= 2'h0;
    refresh_ms <= 12'd10;
    slow       <= 1'b1;
    repeat (2) wait_tick();
    chk("frame lost", status_word[SB_FRAME_LOST], 1'b1);
    chk("overload short refresh", status_word[SB_TX_TMO], 1'b1);
    @(posedge clk);
    refresh_ms <= 12'd45;
    slow       <= 1'b0;
    repeat (2) wait_tick();
    chk("overload cleared", status_word[SB_TX_TMO], 1'b0);
    $display("test_load done");
  endtask : test_load

  task automatic test_bus;
    for (int b = 0; b < 2; b++) begin
      @(posedge clk);
      bus_off    <= (b == 0);
      can_tx_tmo <= (b == 1);
      repeat (3) @(negedge clk);
      chk("error bit set", status_word[1:0], b ? 2'b10 : 2'b01);
      @(posedge clk);
      bus_off    <= 1'b0;
      can_tx_tmo <= 1'b0;
      repeat (3) @(negedge clk);
      chk("error bit clear", status_word[1:0], 2'b00);
    end
    $display("test_bus done");
  endtask : test_bus

  task automatic test_role;
    // A short cycle again keeps the run well inside the watchdog.
    @(posedge clk);
    refresh_ms <= 12'd45;
    drop_node = 6'd1;
    repeat (2) wait_tick();
    host_rw(1'b0, 3'h5, 8'h00, 16'h0000);
    chk("master tmo", rd, 16'h0002);
    @(posedge clk);
    role_master <= 1'b0;
    host_rw(1'b0, 3'h5, 8'h00, 16'h0000);
    chk("slave role tmo", rd, 16'h0000);
    $display("test_role done");
  endtask : test_role

  initial begin
    #600000;
    errors++;
    close_out();
  end

  initial begin
    {rst, role_master, tbl_we, host_rd, host_wr, node_err, bus_off, can_tx_tmo, slow} = 9'h100;
    {rate_sel, tmo_area, tmo_base, host_area, host_addr, host_wdata, tbl_node} = '0;
    {refresh_ms, drop_node, tbl_entry, errors, compares} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("status reset", status_word, STATUS_RST);
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      tbl_we    <= 1'b1;
      tbl_node  <= i[5:0];
      tbl_entry <= (i == 1) ? {1'b1, 9'd20, 9'd8} : (i == 2) ? {1'b1, 9'd9, 9'd0} :
                   (i == 40) ? {1'b1, 9'd256, 9'd256} : '0;
    end
    @(posedge clk);
    tbl_we <= 1'b0;
    // refresh above the summed time at 500 kbps
    tmo_area    <= 3'h5;
    tmo_base    <= 8'h20;
    refresh_ms  <= 12'd45;
    role_master <= 1'b1;
    test_scan();
    test_cycle(12'd45, 200);
    test_timeout();
    test_load();
    test_bus();
    test_cycle(12'd99, 500);
    test_cycle(12'd3000, 10000);
    test_role();
    close_out();
  end
endmodule : tb_fieldbus_master_scan_scheduler
